// [core/opm_map.svh]
// register offsets, field positions, reset values and timing counts
`ifndef OPM_MAP_SVH
`define OPM_MAP_SVH
`define OPM_AW            12
`define OPM_MODE_IDX      12'h095
`define OPM_P1W_IDX       12'h0C0
`define OPM_STAT_IDX      12'h096
`define OPM_ADDR(idx)     ((idx) << 2)
`define OPM_HSTOP_BIT     1
`define OPM_SLOW_BIT      2
`define OPM_CPUM_LSB      3
`define OPM_CPUM_MSB      4
`define OPM_CPUM_NORMAL   2'h0
`define OPM_CPUM_SLEEP    2'h1
`define OPM_CPUM_GREEN    2'h2
`define OPM_P1W_RESET     4'h0
`define OPM_P0_W          8
`define OPM_P1_W          4
`define OPM_SYNC_W        14
`define OPM_HOSC_IDX      12
`define OPM_LOSC_IDX      13
`define OPM_WARM_CLKS     32
`define OPM_WARM_LAST     5'h1F
`define OPM_SLOW_DIV_LAST 2'h3
`endif

// [core/opm_pkg.sv]
// types shared by the operating-mode controller
package opm_pkg;
  typedef enum logic [1:0] {OPM_RUN, OPM_GREEN, OPM_SLEEP, OPM_WARM} opm_state_e;

  typedef struct packed {
    logic [13:0] meta;
    logic [13:0] sync;
    logic [13:0] prev;
  } opm_sync_s;

  typedef struct packed {
    opm_state_e  st;
    logic        sleep_b;
    logic        idle_b;
    logic        slow_b;
    logic        hstop;
    logic [3:0]  p1w;
    logic [4:0]  warm_cnt;
    logic [1:0]  slow_div;
    logic        cpu_step;
    logic        cpu_run;
    logic        tmr_act;
    logic        hosc_en;
    logic        losc_en;
    logic        slow_sel;
    logic        woke;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } opm_regs_s;
endpackage : opm_pkg

// [core/opm_sync_edge.sv]
// two-flop synchroniser and change detector for pins and oscillator taps
`timescale 1ns/1ns
`default_nettype none
`include "opm_map.svh"
module opm_sync_edge (
  input  wire logic                   clock,
  input  wire logic                   nrst,
  input  wire logic                   clk_en,
  input  wire logic [`OPM_SYNC_W-1:0] din,
  output logic      [`OPM_SYNC_W-1:0] lvl,
  output logic      [`OPM_SYNC_W-1:0] chg
);
  opm_pkg::opm_sync_s r;
  opm_pkg::opm_sync_s next_r;

  // shift the pins through meta, sync and prev
  always_comb begin
    next_r      = r;
    next_r.meta = din;
    next_r.sync = r.meta;
    next_r.prev = r.sync;
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      r <= '0;
    end else if (clk_en) begin
      r <= next_r;
    end
  end

  assign lvl = r.sync;

  // either edge of each synced bit counts as a change
  genvar i;
  generate
    for (i = 0; i < `OPM_SYNC_W; i++) begin : g_chg
      assign chg[i] = r.sync[i] ^ r.prev[i];
    end
  endgenerate
endmodule : opm_sync_edge
`default_nettype wire

// [core/opm_ctrl.sv]
// operating-mode and wake-up controller with apb registers
// Function
// - reset enters normal mode on high oscillator
// - slow bit selects low osc, rate over four
// - slow entry leaves high oscillator stop alone
// - sleep bit halts cpu, stops both oscillators
// - sleep wake clears bit, resumes normal
// - idle bit enters green, cleared on wake
// - green wake returns to previous normal/slow
// - green stops cpu, clock and timers run
// - green wakes on pins or timer0 overflow
// - power-down wakes only on pin change
// - power-down wake waits 32 high clocks
// - green wake has no delay
// - any enabled pin level change triggers wake
// - port0 always wakes, port1 per enable bit
// - high stop in normal acts as power-down
// - timer in pwm use does not wake
// - mode register holds mode, slow, stop bits
// - high stop halts high osc, low runs
`timescale 1ns/1ns
`default_nettype none
`include "opm_map.svh"
module opm_ctrl (
  input  wire logic                 clock,
  input  wire logic                 nrst,
  input  wire logic                 clk_en,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [`OPM_AW-1:0]   paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic [`OPM_P0_W-1:0] port0_pins,
  input  wire logic [`OPM_P1_W-1:0] port1_pins,
  input  wire logic                 hosc_tap,
  input  wire logic                 losc_tap,
  input  wire logic                 timer0_overflow,
  input  wire logic                 timer_pwm_use,
  output logic                      hosc_en,
  output logic                      losc_en,
  output logic                      slow_clk_sel,
  output logic                      cpu_run,
  output logic                      cpu_step,
  output logic                      timers_active,
  output logic                      wake_pulse
);
  opm_pkg::opm_regs_s r;
  opm_pkg::opm_regs_s next_r;
  logic [`OPM_SYNC_W-1:0] s_lvl;
  logic [`OPM_SYNC_W-1:0] s_chg;
  logic                   pin_wake;
  logic                   green_wake;
  logic                   hosc_edge;
  logic                   losc_edge;
  logic                   wr;
  logic [1:0]             cpum;

  // address match for one register index
  function automatic logic hit(input logic [`OPM_AW-1:0] a, input logic [`OPM_AW-1:0] idx);
    hit = (a == `OPM_ADDR(idx));
  endfunction : hit

  // all pins and oscillator taps come from outside the clock domain
  opm_sync_edge u_sync (
    .clock  (clock),
    .nrst   (nrst),
    .clk_en (clk_en),
    .din    ({losc_tap, hosc_tap, port1_pins, port0_pins}),
    .lvl    (s_lvl),
    .chg    (s_chg)
  );

  // wake sources and oscillator edges
  always_comb begin
    pin_wake   = (|s_chg[`OPM_P0_W-1:0]) | (|(s_chg[11:8] & r.p1w));
    green_wake = pin_wake | (timer0_overflow & ~timer_pwm_use);
    hosc_edge  = s_chg[`OPM_HOSC_IDX] & s_lvl[`OPM_HOSC_IDX];
    losc_edge  = s_chg[`OPM_LOSC_IDX] & s_lvl[`OPM_LOSC_IDX];
    wr         = psel & penable & r.pready & pwrite;
    cpum       = pwdata[`OPM_CPUM_MSB:`OPM_CPUM_LSB];
  end

  // next state of bus, register file and mode sequencer
  always_comb begin
    next_r          = r;
    next_r.cpu_step = 1'b0;
    next_r.woke     = 1'b0;
    next_r.pready   = psel & penable & ~r.pready;
    if (psel & penable & ~r.pready) begin
      next_r.pslverr = ~(hit(paddr, `OPM_MODE_IDX) | hit(paddr, `OPM_P1W_IDX)
                         | hit(paddr, `OPM_STAT_IDX));
      next_r.prdata  = 32'h0000_0000;
      if (!pwrite && hit(paddr, `OPM_MODE_IDX)) begin
        next_r.prdata[`OPM_CPUM_MSB:`OPM_CPUM_LSB] = {r.idle_b, r.sleep_b};
        next_r.prdata[`OPM_SLOW_BIT]  = r.slow_b;
        next_r.prdata[`OPM_HSTOP_BIT] = r.hstop;
      end else if (!pwrite && hit(paddr, `OPM_STAT_IDX)) begin
        next_r.prdata[5:0] = {r.slow_sel, r.losc_en, r.hosc_en, r.cpu_run, r.st};
      end
    end
    if (wr && hit(paddr, `OPM_MODE_IDX)) begin
      next_r.hstop   = pwdata[`OPM_HSTOP_BIT];
      next_r.slow_b  = pwdata[`OPM_SLOW_BIT];
      next_r.sleep_b = (cpum == `OPM_CPUM_SLEEP);
      next_r.idle_b  = (cpum == `OPM_CPUM_GREEN);
    end
    if (wr && hit(paddr, `OPM_P1W_IDX)) begin
      next_r.p1w = pwdata[`OPM_P1_W-1:0];
    end
    case (r.st)
      opm_pkg::OPM_RUN: begin
        if ((next_r.sleep_b || next_r.idle_b) && pin_wake) begin
          next_r.sleep_b = 1'b0;
          next_r.idle_b  = 1'b0;
          next_r.woke    = 1'b1;
        end else if (next_r.sleep_b) begin
          next_r.st = opm_pkg::OPM_SLEEP;
        end else if (next_r.idle_b) begin
          if (timer0_overflow && !timer_pwm_use) begin
            next_r.idle_b = 1'b0;
            next_r.woke   = 1'b1;
          end else begin
            next_r.st = opm_pkg::OPM_GREEN;
          end
        end else if (!next_r.slow_b && next_r.hstop && !pin_wake) begin
          next_r.st = opm_pkg::OPM_SLEEP;
        end else if (r.slow_b) begin
          // slow rate is low clock over four
          if (losc_edge) begin
            next_r.slow_div = r.slow_div + 2'h1;
            next_r.cpu_step = (r.slow_div == `OPM_SLOW_DIV_LAST);
          end
        end else begin
          // normal steps on the high clock
          next_r.cpu_step = hosc_edge;
          next_r.slow_div = 2'h0;
        end
      end
      opm_pkg::OPM_GREEN: begin
        if (green_wake) begin
          next_r.idle_b = 1'b0;
          next_r.woke   = 1'b1;
          next_r.st     = opm_pkg::OPM_RUN;
        end
      end
      opm_pkg::OPM_SLEEP: begin
        // clear sleep bit, come back normal
        if (pin_wake) begin
          next_r.sleep_b  = 1'b0;
          next_r.hstop    = 1'b0;
          next_r.slow_b   = 1'b0;
          next_r.woke     = 1'b1;
          next_r.warm_cnt = 5'h00;
          next_r.st       = opm_pkg::OPM_WARM;
        end
      end
      opm_pkg::OPM_WARM: begin
        if (hosc_edge) begin
          next_r.warm_cnt = r.warm_cnt + 5'h01;
          if (r.warm_cnt == `OPM_WARM_LAST) begin
            next_r.st = opm_pkg::OPM_RUN;
          end
        end
      end
      default: next_r.st = opm_pkg::OPM_RUN;
    endcase
    // stop bit gates only the high oscillator
    // slow mode keeps the stop bit as written
    next_r.hosc_en  = (next_r.st == opm_pkg::OPM_WARM)
                      | ((next_r.st != opm_pkg::OPM_SLEEP) & ~next_r.hstop);
    // sleep bit stops the low oscillator too
    next_r.losc_en  = ~((next_r.st == opm_pkg::OPM_SLEEP) & next_r.sleep_b);
    // green keeps clock and timers, halts cpu
    next_r.cpu_run  = (next_r.st == opm_pkg::OPM_RUN);
    next_r.tmr_act  = (next_r.st == opm_pkg::OPM_RUN) | (next_r.st == opm_pkg::OPM_GREEN);
    next_r.slow_sel = next_r.slow_b & (next_r.st != opm_pkg::OPM_WARM);
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      r         <= '0;
      r.st      <= opm_pkg::OPM_RUN;
      r.p1w     <= `OPM_P1W_RESET;
      r.hosc_en <= 1'b1;
      r.losc_en <= 1'b1;
      r.cpu_run <= 1'b1;
      r.tmr_act <= 1'b1;
    end else if (clk_en) begin
      r <= next_r;
    end
  end

  // outputs straight from the state register
  assign prdata        = r.prdata;
  assign pready        = r.pready;
  assign pslverr       = r.pslverr;
  assign hosc_en       = r.hosc_en;
  assign losc_en       = r.losc_en;
  assign slow_clk_sel  = r.slow_sel;
  assign cpu_run       = r.cpu_run;
  assign cpu_step      = r.cpu_step;
  assign timers_active = r.tmr_act;
  assign wake_pulse    = r.woke;

  // checks on the sequencer
  reset_normal_a: assert property (@(posedge clock) !nrst |=> r.st == opm_pkg::OPM_RUN && r.hosc_en)
    else $error("reset did not enter normal mode");
  slow_rate_a: assert property (@(posedge clock) disable iff (!nrst)
    clk_en && r.st == opm_pkg::OPM_RUN && r.slow_b && !r.sleep_b && !r.idle_b && !pin_wake
    && !wr && losc_edge && r.slow_div != `OPM_SLOW_DIV_LAST |=> !cpu_step)
    else $error("slow step not every fourth low clock");
  slow_keeps_hosc_a: assert property (@(posedge clock) disable iff (!nrst)
    clk_en && wr && hit(paddr, `OPM_MODE_IDX) && pwdata[4:1] == 4'h2 && r.st == opm_pkg::OPM_RUN
    |=> hosc_en && slow_clk_sel)
    else $error("slow entry stopped high oscillator");
  sleep_stops_a: assert property (@(posedge clock) disable iff (!nrst)
    r.st == opm_pkg::OPM_SLEEP && r.sleep_b |-> !hosc_en && !losc_en && !cpu_run && !timers_active)
    else $error("power-down left a clock running");
  sleep_wake_a: assert property (@(posedge clock) disable iff (!nrst)
    clk_en && r.st == opm_pkg::OPM_SLEEP && pin_wake
    |=> r.st == opm_pkg::OPM_WARM && !r.sleep_b && !r.slow_b && wake_pulse)
    else $error("power-down wake wrong");
  green_back_a: assert property (@(posedge clock) disable iff (!nrst)
    clk_en && r.st == opm_pkg::OPM_GREEN && green_wake
    |=> cpu_run && !r.idle_b && slow_clk_sel == $past(r.slow_b))
    else $error("green wake did not restore mode");
  green_clock_a: assert property (@(posedge clock) disable iff (!nrst)
    r.st == opm_pkg::OPM_GREEN |-> timers_active && !cpu_run && hosc_en == !r.hstop && losc_en)
    else $error("green clocking wrong");
  pd_timer_a: assert property (@(posedge clock) disable iff (!nrst)
    r.st == opm_pkg::OPM_SLEEP && !pin_wake |=> r.st == opm_pkg::OPM_SLEEP)
    else $error("power-down left without pin change");
  warm_len_a: assert property (@(posedge clock) disable iff (!nrst)
    r.st == opm_pkg::OPM_WARM && !(clk_en && hosc_edge && r.warm_cnt == `OPM_WARM_LAST)
    |=> r.st == opm_pkg::OPM_WARM && !cpu_run)
    else $error("warm-up cut short");
  p1_mask_a: assert property (@(posedge clock) disable iff (!nrst)
    r.st == opm_pkg::OPM_SLEEP && s_chg[7:0] == 8'h00 && (s_chg[11:8] & r.p1w) == 4'h0
    |=> r.st == opm_pkg::OPM_SLEEP)
    else $error("masked port1 pin woke the device");
  pwm_nowake_a: assert property (@(posedge clock) disable iff (!nrst)
    r.st == opm_pkg::OPM_GREEN && timer_pwm_use && !pin_wake |=> r.st == opm_pkg::OPM_GREEN)
    else $error("pwm timer woke green mode");
  entry_wake_a: assert property (@(posedge clock) disable iff (!nrst)
    clk_en && r.st == opm_pkg::OPM_RUN && wr && hit(paddr, `OPM_MODE_IDX)
    && (cpum == `OPM_CPUM_SLEEP || cpum == `OPM_CPUM_GREEN) && pin_wake
    |=> cpu_run && !r.sleep_b && !r.idle_b && wake_pulse)
    else $error("wake during entry lost");

  // main scenarios
  sleep_cycle_c: cover property (@(posedge clock) disable iff (!nrst)
    r.st == opm_pkg::OPM_WARM ##1 r.st == opm_pkg::OPM_WARM [*2] ##[1:200] cpu_run);
  green_slow_c: cover property (@(posedge clock) disable iff (!nrst)
    r.st == opm_pkg::OPM_GREEN && r.slow_b ##1 cpu_run);
  no_clock_c: cover property (@(posedge clock) disable iff (!nrst)
    r.st == opm_pkg::OPM_SLEEP && !r.sleep_b && losc_en);
endmodule : opm_ctrl
`default_nettype wire

// [sim/opm_far.sv]
// far-side model: oscillator taps gated by their enables and a timer0 overflow source
`timescale 1ns/1ns
`default_nettype none
module opm_far (
  input  wire logic clock,
  input  wire logic nrst,
  input  wire logic hosc_en,
  input  wire logic losc_en,
  input  wire logic timers_active,
  input  wire logic fire,
  output logic      hosc_tap,
  output logic      losc_tap,
  output logic      timer0_overflow
);
  logic       hdiv;
  logic [2:0] ldiv;
  // taps run at a quarter and a sixteenth of the clock, and freeze where they stand when disabled
  always_ff @(posedge clock) begin
    if (!nrst) begin
      hdiv            <= 1'b0;
      ldiv            <= 3'h0;
      hosc_tap        <= 1'b0;
      losc_tap        <= 1'b0;
      timer0_overflow <= 1'b0;
    end else begin
      if (hosc_en) begin
        hdiv <= ~hdiv;
        if (hdiv) hosc_tap <= ~hosc_tap;
      end
      if (losc_en) begin
        ldiv <= ldiv + 3'h1;
        if (ldiv == 3'h7) losc_tap <= ~losc_tap;
      end
      timer0_overflow <= fire & timers_active;
    end
  end
endmodule : opm_far
`default_nettype wire

// [sim/tb.sv]
// self-checking bench for the operating-mode controller
`timescale 1ns/1ns
`default_nettype none
`include "opm_map.svh"
module tb;
  localparam logic [11:0] A_MODE = 12'(`OPM_ADDR(`OPM_MODE_IDX));
  localparam logic [11:0] A_P1W  = 12'(`OPM_ADDR(`OPM_P1W_IDX));
  localparam logic [11:0] A_STAT = 12'(`OPM_ADDR(`OPM_STAT_IDX));
  logic        clock = 1'b0;
  logic        nrst = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [7:0]  port0_pins = 8'h00;
  logic [3:0]  port1_pins = 4'h0;
  logic        timer_pwm_use = 1'b0;
  logic        fire = 1'b0;
  logic        clk_en = 1'b1;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, er, hosc_en, losc_en, slow_clk_sel, cpu_run, cpu_step;
  logic        timers_active, wake_pulse, hosc_tap, losc_tap, timer0_overflow;
  int          error_cnt = 0;
  int          num_checks = 0;
  int          wcyc, wedge, nstep, nwake;
  always #5 clock = ~clock;
  opm_ctrl u_dut (.clock(clock), .nrst(nrst), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .port0_pins(port0_pins), .port1_pins(port1_pins), .hosc_tap(hosc_tap),
    .losc_tap(losc_tap), .timer0_overflow(timer0_overflow), .timer_pwm_use(timer_pwm_use),
    .hosc_en(hosc_en), .losc_en(losc_en), .slow_clk_sel(slow_clk_sel), .cpu_run(cpu_run),
    .cpu_step(cpu_step), .timers_active(timers_active), .wake_pulse(wake_pulse));
  opm_far u_far (.clock(clock), .nrst(nrst), .hosc_en(hosc_en), .losc_en(losc_en),
    .timers_active(timers_active), .fire(fire), .hosc_tap(hosc_tap), .losc_tap(losc_tap),
    .timer0_overflow(timer0_overflow));
  // verdict and end of run
  task results;
    if (error_cnt == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results
  // compare and report
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // one apb transfer, held until pready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge clock);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clock);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin chk("apb_timeout", 32'h1, 32'h0); results; end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  // wait for execution to resume, counting cycles and high tap edges
  task run_wait(input int bound);
    logic prev;
    prev = hosc_tap; wcyc = 0; wedge = 0; nwake = 0;
    while (cpu_run !== 1'b1) begin
      @(posedge clock);
      wcyc++;
      if (hosc_tap === 1'b1 && prev === 1'b0) wedge++;
      if (wake_pulse === 1'b1) nwake++;
      prev = hosc_tap;
      if (wcyc > bound) begin chk("wait_timeout", 32'h1, 32'h0); results; end
    end
  endtask : run_wait
  // count instruction steps over 256 cycles
  task steps;
    nstep = 0;
    repeat (256) begin @(posedge clock); if (cpu_step === 1'b1) nstep++; end
  endtask : steps
  // one overflow request to the timer model
  task pulse;
    @(posedge clock); fire <= 1'b1;
    @(posedge clock); fire <= 1'b0;
  endtask : pulse
  // main sequence
  initial begin
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    apb(0, A_STAT, 0); chk("stat_reset", rd, 32'h1C);
    apb(0, A_P1W, 0); chk("p1w_read", rd, 32'h0);
    apb(0, 12'h004, 0); chk("unmapped", {31'h0, er}, 32'h1);
    steps; chk("norm_steps", {31'h0, nstep >= 63 && nstep <= 65}, 32'h1);
    clk_en <= 1'b0;
    steps; chk("frozen_steps", {31'h0, nstep == 0 || nstep == 256}, 32'h1);
    clk_en <= 1'b1;
    apb(1, A_MODE, 32'h04); apb(0, A_MODE, 0); chk("mode_slow", rd, 32'h04);
    apb(0, A_STAT, 0); chk("stat_slow", rd, 32'h3C);
    steps; chk("slow_steps", {31'h0, nstep >= 3 && nstep <= 5}, 32'h1);
    apb(1, A_MODE, 32'h14); apb(0, A_STAT, 0); chk("stat_green", rd, 32'h39);
    chk("tmr_green", {31'h0, timers_active}, 32'h1);
    pulse; run_wait(10); chk("green_delay", {31'h0, wcyc <= 5}, 32'h1);
    chk("wake_green", nwake, 32'h1);
    apb(0, A_MODE, 0); chk("mode_green_ret", rd, 32'h04);
    apb(1, A_MODE, 32'h00);
    timer_pwm_use <= 1'b1;
    apb(1, A_MODE, 32'h10); pulse;
    repeat (10) @(posedge clock);
    chk("pwm_no_wake", {31'h0, cpu_run}, 32'h0);
    port0_pins[3] <= 1'b1; run_wait(10);
    apb(0, A_MODE, 0); chk("mode_pin_ret", rd, 32'h00);
    timer_pwm_use <= 1'b0;
    apb(1, A_P1W, 32'h02); apb(1, A_MODE, 32'h0C);
    apb(0, A_STAT, 0); chk("stat_sleep", rd, 32'h22);
    pulse; port1_pins[0] <= 1'b1;
    repeat (20) @(posedge clock);
    chk("sleep_hold", {31'h0, cpu_run}, 32'h0);
    chk("tmr_sleep", {31'h0, timers_active}, 32'h0);
    port1_pins[1] <= 1'b1; run_wait(400);
    chk("warm_edges", {31'h0, wedge >= 31 && wedge <= 34}, 32'h1);
    chk("wake_sleep", nwake, 32'h1);
    apb(0, A_MODE, 0); chk("mode_sleep_ret", rd, 32'h00);
    apb(1, A_MODE, 32'h02); apb(0, A_STAT, 0); chk("stat_nostop", rd, 32'h12);
    port0_pins[3] <= 1'b0; run_wait(400);
    apb(0, A_MODE, 0); chk("mode_nostop_ret", rd, 32'h00);
    apb(1, A_MODE, 32'h06); apb(0, A_STAT, 0); chk("stat_slow_stop", rd, 32'h34);
    apb(1, A_MODE, 32'h00); apb(0, A_STAT, 0); chk("stat_restore", rd, 32'h1C);
    results;
  end
endmodule : tb
`default_nettype wire
